// [design/bit_select.sv]
`timescale 1ns/100ps
// Turns a bit position into a one-hot mask for bit operations.
module bit_select #(
    parameter int WIDTH = 8
) (
    // Position in
    input wire logic [$clog2(WIDTH)-1:0] pos_in,
    // Mask out
    output logic [WIDTH-1:0] mask_out
);
    if (WIDTH < 2) begin : g_bad_width
        $error("bit_select: WIDTH must be at least 2");
    end

    always_comb begin
        mask_out = '0;
        mask_out[pos_in] = 1'b1;
    end
endmodule

// [design/opdec_consts.svh]
`ifndef OPDEC_CONSTS_SVH
`define OPDEC_CONSTS_SVH

// -----------------------------------------------------------------------------
// Field positions, tags, constants and reset values
// -----------------------------------------------------------------------------
`define DEST_BIT 9
`define ACCESS_BIT 8
`define FAST_BIT 0
`define BITPOS_LSB 9
`define SECOND_WORD_TAG 4'hf
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hf
`define QUARTERS_PER_CYCLE 2'h3
`define TABLE_POINTER_RESET 21'h000000
`define BANK_RESET 4'h0
`define FLAGS_RESET 5'h00

`endif

// [design/opdec_pkg.sv]
package opdec_pkg;

    typedef enum logic [1:0] {
        TBL_NONE = 2'h0,
        TBL_POSTINC = 2'h1,
        TBL_POSTDEC = 2'h2,
        TBL_PREINC = 2'h3
    } table_pointer_update_mode_t;

    typedef enum logic [2:0] {
        LIT_NONE = 3'h1,
        LIT_8 = 3'h2,
        LIT_12 = 3'h4
    } lit_sel_t;

    typedef struct packed {
        logic [11:0] data_addr;
        logic dest_is_file;
        logic [7:0] bit_mask;
        logic [2:0] bit_pos;
        logic [19:0] literal;
        logic [20:0] branch_target;
        logic fast;
        logic is_nop;
        logic two_word;
    } decoded_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
        logic overflow_flag;
        logic negative;
    } alu_flags_t;

endpackage

// [design/operand_field_decoder.sv]
`timescale 1ns/100ps
`include "opdec_consts.svh"
// What this block does
// - Access bit 0 addresses the fixed access region, bank register ignored.
// - Access bit 1 forms address from bank register and 8-bit file field.
// - Destination bit 0 targets working register, 1 targets the file register.
// - Bit operations decode a 3-bit position 0 to 7.
// - Single-word file operand is an 8-bit address 0x00 to 0xFF.
// - Two-word move takes 12-bit source from word one, destination from two.
// - Literals come in 8, 12 and 20 bit widths.
// - Table mode: unchanged, post-increment, post-decrement or pre-increment.
// - Table pointer is a 21-bit program memory address register.
// - Fast bit 1 saves or restores shadow copies; 0 leaves them.
// - Relative branches use two's complement offset; others use direct address.
// - Multiply result held in separate high and low product byte registers.
// - Five ALU flags kept: carry, digit carry, zero, overflow, negative.
// - Don't-care instruction bits are ignored; tools should encode them zero.
// - Second word has top four bits ones; alone it executes as no-operation.
// - Instruction cycle is four oscillator periods; taken changes add a cycle (the strobe here keeps a fixed four-clock period).
module operand_field_decoder
    import opdec_pkg::*;
#(
    parameter int BANK_W = 4,
    parameter int TABLE_POINTER_W = 21
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Instruction word
    input wire logic [15:0] instr_in,
    input wire logic instr_valid_in,
    input wire logic expect_second_in,
    input wire logic [2:0] lit_sel_in,
    input wire logic rel_branch_in,
    input wire logic [10:0] rel_offset_in,
    input wire logic [20:0] pc_in,
    // Datapath control
    input wire logic [BANK_W-1:0] bank_select_register_in,
    input wire logic bank_load_in,
    input wire logic tbl_access_in,
    input wire logic tbl_load_in,
    input wire logic [TABLE_POINTER_W-1:0] tbl_load_val_in,
    input wire logic mul_done_in,
    input wire logic [15:0] product_in,
    input wire logic flags_load_in,
    input wire alu_flags_t flags_in,
    input wire logic call_ret_in,
    input wire logic [7:0] working_register_in,
    // Outputs
    output decoded_t dec_out,
    output logic [20:0] move_src_out,
    output logic [20:0] table_pointer_out,
    output logic [20:0] tbl_addr_out,
    output logic [7:0] product_high_byte_out,
    output logic [7:0] product_low_byte_out,
    output alu_flags_t flags_out,
    output logic [7:0] shadow_working_out,
    output logic [BANK_W-1:0] shadow_bank_out,
    output logic shadow_write_out,
    output logic cycle_strobe_out
);

    // Field packing and the pointer arithmetic assume these widths exactly.
    if (BANK_W != 4 || TABLE_POINTER_W != 21) begin : g_bad_width
        $error("operand_field_decoder: unsupported width");
    end

    // -------------------------------------------------------------------------
    // Instruction cycle divider
    // -------------------------------------------------------------------------
    logic [1:0] quarter_r, quarter_nxt;
    always_comb begin
        quarter_nxt = quarter_r + 2'h1;
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            quarter_r <= 2'h0;
        end else begin
            quarter_r <= quarter_nxt;
        end
    end
    assign cycle_strobe_out = (quarter_r == `QUARTERS_PER_CYCLE);

    // -------------------------------------------------------------------------
    // Combinational field decode
    // -------------------------------------------------------------------------
    logic [BANK_W-1:0] bank_r, bank_nxt;
    logic [11:0] move_src_r, move_src_nxt;
    logic [7:0] mask;
    decoded_t dec_r, dec_nxt;

    bit_select #(.WIDTH(8)) u_bit_select (
        .pos_in(instr_in[`BITPOS_LSB +: 3]),
        .mask_out(mask)
    );

    always_comb begin
        dec_nxt = dec_r;
        if (instr_valid_in) begin
            dec_nxt.two_word = expect_second_in;
            dec_nxt.is_nop = 1'b0;
            dec_nxt.fast = instr_in[`FAST_BIT];
            dec_nxt.bit_pos = instr_in[`BITPOS_LSB +: 3];
            dec_nxt.bit_mask = mask;
            dec_nxt.dest_is_file = instr_in[`DEST_BIT];
            if (!instr_in[`ACCESS_BIT]) begin
                // Low half of the access region maps to bank 0, high half to the SFR bank.
                dec_nxt.data_addr = (instr_in[7:0] < `ACCESS_SPLIT) ? {4'h0, instr_in[7:0]} :
                                    {`ACCESS_HIGH_BANK, instr_in[7:0]};
            end else begin
                dec_nxt.data_addr = {bank_r, instr_in[7:0]};
            end
            case (lit_sel_t'(lit_sel_in))
                LIT_8: dec_nxt.literal = {12'h000, instr_in[7:0]};
                LIT_12: dec_nxt.literal = {8'h00, instr_in[11:0]};
                LIT_NONE: dec_nxt.literal = 20'h00000;
                default: dec_nxt.literal = 20'h00000;
            endcase
            if (expect_second_in) begin
                // Word two of a pair; a stray one with the tag set is a no-operation.
                if (instr_in[15:12] == `SECOND_WORD_TAG) begin
                    dec_nxt.data_addr = instr_in[11:0];
                    dec_nxt.literal = {instr_in[11:0], dec_r.literal[7:0]};
                    dec_nxt.branch_target = {instr_in[11:0], dec_r.literal[7:0], 1'b0};
                end
            end else if (instr_in[15:12] == `SECOND_WORD_TAG) begin
                dec_nxt.is_nop = 1'b1;
            end
            if (rel_branch_in) begin
                dec_nxt.branch_target = pc_in + 21'h2 +
                                        {{9{rel_offset_in[10]}}, rel_offset_in, 1'b0};
            end
        end
    end

    always_comb begin
        bank_nxt = bank_load_in ? bank_select_register_in : bank_r;
        move_src_nxt = move_src_r;
        if (instr_valid_in && !expect_second_in) begin
            move_src_nxt = instr_in[11:0];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dec_r <= '0;
            bank_r <= `BANK_RESET;
            move_src_r <= 12'h000;
        end else begin
            dec_r <= dec_nxt;
            bank_r <= bank_nxt;
            move_src_r <= move_src_nxt;
        end
    end
    // Latched on the same edge as the word, so fields are ready within its cycle.
    assign dec_out = dec_r;
    assign move_src_out = {9'h000, move_src_r};

    // -------------------------------------------------------------------------
    // Table pointer
    // -------------------------------------------------------------------------
    logic [TABLE_POINTER_W-1:0] table_pointer_r, table_pointer_nxt, tbl_addr_r, tbl_addr_nxt;
    table_pointer_update_mode_t table_pointer_update_mode;
    assign table_pointer_update_mode = table_pointer_update_mode_t'(instr_in[1:0]);
    always_comb begin
        table_pointer_nxt = table_pointer_r;
        tbl_addr_nxt = tbl_addr_r;
        if (tbl_load_in) begin
            table_pointer_nxt = tbl_load_val_in;
        end else if (tbl_access_in && instr_valid_in) begin
            tbl_addr_nxt = table_pointer_r;
            case (table_pointer_update_mode)
                TBL_NONE: table_pointer_nxt = table_pointer_r;
                TBL_POSTINC: table_pointer_nxt = table_pointer_r + 21'h1;
                TBL_POSTDEC: table_pointer_nxt = table_pointer_r - 21'h1;
                TBL_PREINC: begin
                    table_pointer_nxt = table_pointer_r + 21'h1;
                    tbl_addr_nxt = table_pointer_r + 21'h1;
                end
                default: table_pointer_nxt = table_pointer_r;
            endcase
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            table_pointer_r <= `TABLE_POINTER_RESET;
            tbl_addr_r <= `TABLE_POINTER_RESET;
        end else begin
            table_pointer_r <= table_pointer_nxt;
            tbl_addr_r <= tbl_addr_nxt;
        end
    end
    assign table_pointer_out = table_pointer_r;
    assign tbl_addr_out = tbl_addr_r;

    // -------------------------------------------------------------------------
    // Product, flags and shadow registers
    // -------------------------------------------------------------------------
    logic [7:0] prod_h_r, prod_h_nxt, prod_l_r, prod_l_nxt, sh_w_r, sh_w_nxt;
    logic [BANK_W-1:0] sh_b_r, sh_b_nxt;
    alu_flags_t flags_r, flags_nxt;
    logic sh_wr;
    always_comb begin
        prod_h_nxt = mul_done_in ? product_in[15:8] : prod_h_r;
        prod_l_nxt = mul_done_in ? product_in[7:0] : prod_l_r;
        flags_nxt = flags_load_in ? flags_in : flags_r;
        // Restore is combinational from the shadows; only save updates them.
        sh_wr = call_ret_in && instr_in[`FAST_BIT] && instr_valid_in;
        sh_w_nxt = sh_wr ? working_register_in : sh_w_r;
        sh_b_nxt = sh_wr ? bank_r : sh_b_r;
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            prod_h_r <= 8'h00;
            prod_l_r <= 8'h00;
            flags_r <= `FLAGS_RESET;
            sh_w_r <= 8'h00;
            sh_b_r <= `BANK_RESET;
        end else begin
            prod_h_r <= prod_h_nxt;
            prod_l_r <= prod_l_nxt;
            flags_r <= flags_nxt;
            sh_w_r <= sh_w_nxt;
            sh_b_r <= sh_b_nxt;
        end
    end
    assign product_high_byte_out = prod_h_r;
    assign product_low_byte_out = prod_l_r;
    assign flags_out = flags_r;
    assign shadow_working_out = sh_w_r;
    assign shadow_bank_out = sh_b_r;
    assign shadow_write_out = sh_wr;

endmodule

// [tb/operand_field_checker.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the operand decoder.
// ----------------------------------------
module operand_field_checker
    import opdec_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Stimulus
    input wire logic [15:0] instr_in,
    input wire logic instr_valid_in,
    input wire logic expect_second_in,
    input wire logic rel_branch_in,
    input wire logic [10:0] rel_offset_in,
    input wire logic [20:0] pc_in,
    input wire logic mul_done_in,
    input wire logic [15:0] product_in,
    input wire logic flags_load_in,
    input wire alu_flags_t flags_in,
    input wire logic call_ret_in,
    // Results
    input wire decoded_t dec_out,
    input wire logic [7:0] product_high_byte_out,
    input wire logic [7:0] product_low_byte_out,
    input wire alu_flags_t flags_out,
    input wire logic [7:0] shadow_working_out,
    input wire logic cycle_strobe_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Tagged words outside a pair are excluded, since they decode as no-operation.
    logic one_w;
    assign one_w = instr_valid_in && !expect_second_in && instr_in[15:12] != 4'hf;
    a_strobe_gap: assert property (cycle_strobe_out |=> (!cycle_strobe_out) [*3] ##1 cycle_strobe_out)
        else $error("cycle strobe spacing wrong");
    a_access_fixed: assert property (one_w && !instr_in[8] |=>
        dec_out.data_addr == {($past(instr_in[7]) ? 4'hf : 4'h0), $past(instr_in[7:0])})
        else $error("access region address wrong");
    a_dest_bit: assert property (one_w |=> dec_out.dest_is_file == $past(instr_in[9]))
        else $error("destination select wrong");
    a_bit_mask: assert property (one_w |=> dec_out.bit_pos == $past(instr_in[11:9]) &&
        dec_out.bit_mask == (8'h01 << $past(instr_in[11:9])))
        else $error("bit position or mask wrong");
    a_fast_bit: assert property (one_w |=> dec_out.fast == $past(instr_in[0]))
        else $error("fast bit wrong");
    a_stray_nop: assert property (instr_valid_in && !expect_second_in && instr_in[15:12] == 4'hf |=>
        dec_out.is_nop)
        else $error("stray second word not a no-operation");
    a_rel_target: assert property (instr_valid_in && rel_branch_in |=> dec_out.branch_target ==
        $past(pc_in) + 21'h000002 + {{9{$past(rel_offset_in[10])}}, $past(rel_offset_in), 1'b0})
        else $error("relative branch target wrong");
    a_product_load: assert property (mul_done_in |=>
        {product_high_byte_out, product_low_byte_out} == $past(product_in))
        else $error("product bytes wrong");
    a_flags_load: assert property (flags_load_in |=> flags_out == $past(flags_in))
        else $error("flags not loaded");
    a_shadow_hold: assert property (!(call_ret_in && instr_valid_in && instr_in[0]) |=>
        $stable(shadow_working_out))
        else $error("shadow copy changed without fast mode");
endmodule

bind operand_field_decoder operand_field_checker chk (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .instr_in(instr_in),
    .instr_valid_in(instr_valid_in),
    .expect_second_in(expect_second_in),
    .rel_branch_in(rel_branch_in),
    .rel_offset_in(rel_offset_in),
    .pc_in(pc_in),
    .mul_done_in(mul_done_in),
    .product_in(product_in),
    .flags_load_in(flags_load_in),
    .flags_in(flags_in),
    .call_ret_in(call_ret_in),
    .dec_out(dec_out),
    .product_high_byte_out(product_high_byte_out),
    .product_low_byte_out(product_low_byte_out),
    .flags_out(flags_out),
    .shadow_working_out(shadow_working_out),
    .cycle_strobe_out(cycle_strobe_out)
);

// [tb/tb_top.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench for the operand decoder.
// ----------------------------------------
module tb_top
    import opdec_pkg::*;
;
    logic mclk_in = 1'b0, rst_in = 1'b1, instr_valid_in = 1'b0, expect_second_in = 1'b0, rel_branch_in = 1'b0;
    logic bank_load_in = 1'b0, tbl_access_in = 1'b0, tbl_load_in = 1'b0, mul_done_in = 1'b0;
    logic flags_load_in = 1'b0, call_ret_in = 1'b0;
    logic [15:0] instr_in = 16'h0000, product_in = 16'h0000;
    logic [2:0] lit_sel_in = 3'h1;
    logic [10:0] rel_offset_in = 11'h000;
    logic [20:0] pc_in = 21'h000100, tbl_load_val_in = 21'h1ffffe;
    logic [3:0] bank_select_register_in = 4'h0;
    logic [7:0] working_register_in = 8'h00;
    alu_flags_t flags_in = 5'h00;
    decoded_t dec_out;
    alu_flags_t flags_out;
    logic [20:0] move_src_out, table_pointer_out, tbl_addr_out, p;
    logic [7:0] product_high_byte_out, product_low_byte_out, shadow_working_out;
    logic [3:0] shadow_bank_out;
    logic shadow_write_out, cycle_strobe_out;
    logic [1:0] m;
    int err_count = 0, samples_checked = 0, n;
    always #20 mclk_in = ~mclk_in;
    operand_field_decoder dut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .instr_in(instr_in),
        .instr_valid_in(instr_valid_in),
        .expect_second_in(expect_second_in),
        .lit_sel_in(lit_sel_in),
        .rel_branch_in(rel_branch_in),
        .rel_offset_in(rel_offset_in),
        .pc_in(pc_in),
        .bank_select_register_in(bank_select_register_in),
        .bank_load_in(bank_load_in),
        .tbl_access_in(tbl_access_in),
        .tbl_load_in(tbl_load_in),
        .tbl_load_val_in(tbl_load_val_in),
        .mul_done_in(mul_done_in),
        .product_in(product_in),
        .flags_load_in(flags_load_in),
        .flags_in(flags_in),
        .call_ret_in(call_ret_in),
        .working_register_in(working_register_in),
        .dec_out(dec_out),
        .move_src_out(move_src_out),
        .table_pointer_out(table_pointer_out),
        .tbl_addr_out(tbl_addr_out),
        .product_high_byte_out(product_high_byte_out),
        .product_low_byte_out(product_low_byte_out),
        .flags_out(flags_out),
        .shadow_working_out(shadow_working_out),
        .shadow_bank_out(shadow_bank_out),
        .shadow_write_out(shadow_write_out),
        .cycle_strobe_out(cycle_strobe_out)
    );
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Inputs change 1 ns after a rising edge; the word is taken at the next edge.
    task put(input logic [15:0] w, input logic sec);
        instr_in = w;
        instr_valid_in = 1'b1;
        expect_second_in = sec;
        @(posedge mclk_in);
        #1;
    endtask
    task t_access;
        for (int i = 0; i < 2; i++) begin
            bank_select_register_in = i ? 4'ha : 4'h5;
            bank_load_in = 1'b1;
            put(16'h027f, 1'b0);
            bank_load_in = 1'b0;
            put(16'h027f, 1'b0);
            chk(dec_out.data_addr, 12'h07f);
            chk(dec_out.dest_is_file, 1'b1);
            put(16'h0080, 1'b0);
            chk(dec_out.data_addr, 12'hf80);
            chk(dec_out.dest_is_file, 1'b0);
            put(16'h01ff, 1'b0);
            chk(dec_out.data_addr, {bank_select_register_in, 8'hff});
            put(16'h0100, 1'b0);
            chk(dec_out.data_addr, {bank_select_register_in, 8'h00});
        end
    endtask
    task t_bits;
        for (int b = 0; b < 8; b++) begin
            put({4'h9, b[2:0], 9'h012}, 1'b0);
            chk(dec_out.bit_pos, b);
            chk(dec_out.bit_mask, 8'h01 << b);
        end
    endtask
    task t_lit;
        lit_sel_in = 3'h2;
        put(16'h0e7f, 1'b0);
        chk(dec_out.literal[7:0], 8'h7f);
        put(16'h0b7f, 1'b0);
        chk(dec_out.literal, 20'h0007f);
        lit_sel_in = 3'h4;
        put(16'hefab, 1'b0);
        chk(dec_out.literal[11:0], 12'hfab);
        lit_sel_in = 3'h1;
    endtask
    task t_move;
        put(16'hcfff, 1'b0);
        chk(move_src_out, 21'h000fff);
        put(16'hf000, 1'b1);
        chk(dec_out.data_addr, 12'h000);
        chk(dec_out.two_word, 1'b1);
        lit_sel_in = 3'h2;
        put(16'hef12, 1'b0);
        put(16'hf345, 1'b1);
        chk(dec_out.literal, 20'h34512);
        chk(dec_out.branch_target, 21'h068a24);
        lit_sel_in = 3'h1;
        put(16'hfabc, 1'b0);
        chk(dec_out.is_nop, 1'b1);
        put(16'h0000, 1'b0);
        chk(dec_out.is_nop, 1'b0);
    endtask
    // The pointer starts at 0x1FFFFE, one below the top, so the 21-bit wrap is crossed both ways.
    task t_table;
        tbl_load_in = 1'b1;
        put(16'h0000, 1'b0);
        tbl_load_in = 1'b0;
        p = 21'h1ffffe;
        tbl_access_in = 1'b1;
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 2'h0 : (i < 3) ? 2'h1 : (i == 3) ? 2'h2 : 2'h3;
            put({14'h0002, m}, 1'b0);
            chk(tbl_addr_out, (m == 2'h3) ? 21'(p + 21'h000001) : p);
            p = (m == 2'h1 || m == 2'h3) ? p + 21'h000001 : (m == 2'h2) ? p - 21'h000001 : p;
            chk(table_pointer_out, p);
        end
        tbl_access_in = 1'b0;
    endtask
    task t_branch;
        rel_branch_in = 1'b1;
        rel_offset_in = 11'h400;
        put(16'hd400, 1'b0);
        chk(dec_out.branch_target, 21'h1ff902);
        rel_offset_in = 11'h3ff;
        put(16'hd3ff, 1'b0);
        chk(dec_out.branch_target, 21'h000900);
        rel_branch_in = 1'b0;
    endtask
    task t_mul;
        for (int i = 0; i < 2; i++) begin
            product_in = i ? 16'h00ff : 16'ha55a;
            flags_in = i ? 5'h0a : 5'h15;
            mul_done_in = 1'b1;
            flags_load_in = 1'b1;
            put(16'h0000, 1'b0);
            chk({product_high_byte_out, product_low_byte_out}, product_in);
            chk(flags_out, flags_in);
        end
        mul_done_in = 1'b0;
        flags_load_in = 1'b0;
    endtask
    task t_shadow;
        call_ret_in = 1'b1;
        for (int i = 1; i >= 0; i--) begin
            working_register_in = i ? 8'h3c : 8'hc3;
            instr_in = {15'h0009, i[0]};
            #2;
            chk(shadow_write_out, i[0]);
            @(posedge mclk_in);
            #1;
            chk(shadow_working_out, 8'h3c);
            chk(shadow_bank_out, 4'ha);
        end
        call_ret_in = 1'b0;
    endtask
    task t_strobe;
        n = 0;
        repeat (40) begin
            @(posedge mclk_in);
            #1;
            n += (cycle_strobe_out === 1'b1);
        end
        chk(n, 10);
    endtask
    task finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // The run needs under a hundred cycles; the limit of 5000 cycles leaves wide margin for a hang.
    initial begin
        #200000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge mclk_in);
        #1;
        chk(|{dec_out, table_pointer_out, flags_out, product_high_byte_out, shadow_working_out}, 1'b0);
        rst_in = 1'b0;
        t_access;
        t_bits;
        t_lit;
        t_move;
        t_table;
        t_branch;
        t_mul;
        t_shadow;
        t_strobe;
        finish_test;
    end
endmodule
